// file: ds3_feac_defines.svh
// Behaviour
// - Continuous mode repeats alarm code without gaps
// - Otherwise FEAC bit follows programmed C-bit
// - Burst starts on panel or software trigger
// - After burst, previous FEAC setting resumes
// - Burst type selects none, up, down, alarm
// - Alarm burst sends code count times
// - Line identifier is six bits, MSB first
// - Alarm code is six bits, MSB first
// - Alarm code feeds continuous and alarm bursts
// - Any C-bit settable by row and position
// - Last received code kept for readback
// - Seconds since any received code
// - Last sequence type activate or deactivate
// - Seconds since last loopback sequence
// - Line of last loopback sequence kept
`ifndef DS3_FEAC_DEFINES_SVH
`define DS3_FEAC_DEFINES_SVH

// Register indices
`define REG_CTRL 4'h0
`define REG_ALARM 4'h1
`define REG_LINE 4'h2
`define REG_CBIT_TABLE 4'h3
`define REG_CBIT_SET 4'h4
`define REG_ACTION 4'h5
`define REG_RX_CODE 4'h6
`define REG_RX_SEQ 4'h7
`define REG_SEC_CODE 4'h8
`define REG_SEC_SEQ 4'h9
`define REG_INT_STATUS 4'hA
`define REG_INT_MASK 4'hB
`define REG_STATUS 4'hC

// Control field layout
`define CTRL_CONT_BIT 0
`define CTRL_KIND_LSB 1
`define CTRL_KIND_MSB 2
`define CTRL_COUNT_LSB 4
`define CTRL_COUNT_MSB 7
`define COUNT_RESET 4'h3

// C-bit set field layout
`define CSET_ROW_LSB 0
`define CSET_ROW_MSB 2
`define CSET_POS_LSB 4
`define CSET_POS_MSB 5
`define CSET_VAL_BIT 8
`define RX_SEQ_LINE_LSB 8

// Burst type encodings
`define KIND_NONE 2'h0
`define KIND_ACTIVATE 2'h1
`define KIND_DEACTIVATE 2'h2
`define KIND_ALARM 2'h3

// Loop control codes
`define LOOP_UP_CODE 6'h07
`define LOOP_DOWN_CODE 6'h1C

// C-bit geometry and FEAC slot
`define CBIT_COUNT 21
`define FEAC_ROW 3'h1
`define FEAC_POS 2'h3
`define CBIT_RESET 21'h1FFFFF

// Codeword layout
`define WORD_ONES 8'hFF
`define WORD_LAST_IDX 4'hF

// Interrupt bits
`define INT_RX_CODE 0
`define INT_RX_SEQ 1
`define INT_BURST_DONE 2
`define INT_WIDTH 3

// Seconds tick
`define SECOND_S 1
`define CLK_HZ 200000000
`define TICKS_PER_SECOND (`SECOND_S * `CLK_HZ)

`endif

// file: ds3_feac_pkg.sv
package ds3_feac_pkg;

  // Transmit burst sequencer
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_CODE,
    TX_LINE
  } tx_state_t;

endpackage

// file: ds3_feac_channel_control.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "ds3_feac_defines.svh"

module ds3_feac_channel_control #(
  parameter int unsigned TICKS_PER_SECOND = `TICKS_PER_SECOND
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Front panel trigger
  input wire logic inject_key,
  // Transmit C-bit slots
  input wire logic tx_cbit_req,
  input wire logic [2:0] tx_cbit_row,
  input wire logic [1:0] tx_cbit_pos,
  output logic tx_cbit_out,
  // Received FEAC bits, one per frame
  input wire logic rx_feac_valid,
  input wire logic rx_feac_bit,
  // Interrupt
  output logic irq
);

  // Bit index of a C-bit in the table
  function automatic logic [4:0] cbit_index(input logic [2:0] row, input logic [1:0] pos);
    logic [4:0] r;
    logic [4:0] p;
    r = {2'h0, row} - 5'h01;
    p = {3'h0, pos} - 5'h01;
    cbit_index = 5'((r << 1) + r + p);
  endfunction

  // Row and position in range
  function automatic logic cbit_valid(input logic [2:0] row, input logic [1:0] pos);
    cbit_valid = (row != 3'h0) && (pos != 2'h0);
  endfunction

  // Sixteen-bit codeword for a code
  function automatic logic [15:0] codeword(input logic [5:0] code);
    codeword = {1'b0, code, 1'b0, `WORD_ONES};
  endfunction

  // Register state
  logic cont_ff, nxt_cont;
  logic [1:0] kind_sel_ff, nxt_kind_sel;
  logic [3:0] count_ff, nxt_count;
  logic [5:0] alarm_status_code_ff, nxt_alarm_status_code;
  logic [5:0] line_ff, nxt_line;
  logic [`CBIT_COUNT-1:0] cbit_ff, nxt_cbit;
  logic [`INT_WIDTH-1:0] int_status_ff, nxt_int_status;
  logic [`INT_WIDTH-1:0] int_mask_ff, nxt_int_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic sw_trigger;

  // Transmit state
  ds3_feac_pkg::tx_state_t tx_state_ff, nxt_tx_state;
  logic [1:0] kind_ff, nxt_kind;
  logic [3:0] rep_ff, nxt_rep;
  logic [3:0] bit_idx_ff, nxt_bit_idx;
  logic [5:0] cur_code_ff, nxt_cur_code;
  logic tx_out_ff, nxt_tx_out;
  logic burst_done;

  // Receive state
  logic [15:0] rx_sr_ff, nxt_rx_sr;
  logic [5:0] last_rx_code_ff, nxt_last_rx_code;
  logic last_rx_sequence_type_ff, nxt_last_rx_sequence_type;
  logic [5:0] last_rx_line_ff, nxt_last_rx_line;
  logic pend_ff, nxt_pend;
  logic pend_kind_ff, nxt_pend_kind;
  logic rx_code_evt;
  logic rx_seq_evt;

  // Seconds state
  logic [31:0] tick_ff, nxt_tick;
  logic [31:0] seconds_since_rx_code_ff, nxt_seconds_since_rx_code;
  logic [31:0] seconds_since_rx_sequence_ff, nxt_seconds_since_rx_sequence;
  logic sec_pulse;

  // Decoded FEAC slot and word end
  logic feac_slot;
  logic word_end;
  logic feac_bit;
  logic [15:0] cur_word;

  assign reg_rdata = rdata_ff;
  assign tx_cbit_out = tx_out_ff;
  assign irq = irq_ff;

  assign feac_slot = tx_cbit_req && (tx_cbit_row == `FEAC_ROW) && (tx_cbit_pos == `FEAC_POS);
  assign cur_word = codeword(cur_code_ff);
  assign feac_bit = cur_word[4'(`WORD_LAST_IDX - bit_idx_ff)];
  assign sw_trigger = reg_wr && (reg_addr == `REG_ACTION);

  // Register writes, interrupt status and read data
  always_comb begin
    nxt_cont = cont_ff;
    nxt_kind_sel = kind_sel_ff;
    nxt_count = count_ff;
    nxt_alarm_status_code = alarm_status_code_ff;
    nxt_line = line_ff;
    nxt_cbit = cbit_ff;
    nxt_int_mask = int_mask_ff;
    nxt_int_status = int_status_ff;
    nxt_rdata = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          nxt_cont = reg_wdata[`CTRL_CONT_BIT];
          nxt_kind_sel = reg_wdata[`CTRL_KIND_MSB:`CTRL_KIND_LSB];
          nxt_count = reg_wdata[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB];
        end
        `REG_ALARM: nxt_alarm_status_code = reg_wdata[5:0];
        `REG_LINE: nxt_line = reg_wdata[5:0];
        `REG_CBIT_TABLE: nxt_cbit = reg_wdata[`CBIT_COUNT-1:0];
        `REG_CBIT_SET: begin
          if (cbit_valid(reg_wdata[`CSET_ROW_MSB:`CSET_ROW_LSB],
                         reg_wdata[`CSET_POS_MSB:`CSET_POS_LSB])) begin
            nxt_cbit[cbit_index(reg_wdata[`CSET_ROW_MSB:`CSET_ROW_LSB],
                                reg_wdata[`CSET_POS_MSB:`CSET_POS_LSB])] =
              reg_wdata[`CSET_VAL_BIT];
          end
        end
        `REG_INT_STATUS: nxt_int_status = int_status_ff & ~reg_wdata[`INT_WIDTH-1:0];
        `REG_INT_MASK: nxt_int_mask = reg_wdata[`INT_WIDTH-1:0];
        default: nxt_int_mask = int_mask_ff;
      endcase
    end
    // Events set after clear so a set wins
    if (rx_code_evt) begin
      nxt_int_status[`INT_RX_CODE] = 1'b1;
    end
    if (rx_seq_evt) begin
      nxt_int_status[`INT_RX_SEQ] = 1'b1;
    end
    if (burst_done) begin
      nxt_int_status[`INT_BURST_DONE] = 1'b1;
    end
    nxt_irq = |(nxt_int_status & nxt_int_mask);
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: nxt_rdata = {24'h0, count_ff, 1'b0, kind_sel_ff, cont_ff};
        `REG_ALARM: nxt_rdata = {26'h0, alarm_status_code_ff};
        `REG_LINE: nxt_rdata = {26'h0, line_ff};
        `REG_CBIT_TABLE: nxt_rdata = {11'h0, cbit_ff};
        `REG_RX_CODE: nxt_rdata = {26'h0, last_rx_code_ff};
        `REG_RX_SEQ: nxt_rdata = {18'h0, last_rx_line_ff, 7'h0, last_rx_sequence_type_ff};
        `REG_SEC_CODE: nxt_rdata = seconds_since_rx_code_ff;
        `REG_SEC_SEQ: nxt_rdata = seconds_since_rx_sequence_ff;
        `REG_INT_STATUS: nxt_rdata = {29'h0, int_status_ff};
        `REG_INT_MASK: nxt_rdata = {29'h0, int_mask_ff};
        `REG_STATUS: nxt_rdata = {31'h0, tx_state_ff != ds3_feac_pkg::TX_IDLE};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cont_ff <= 1'b0;
      kind_sel_ff <= `KIND_NONE;
      count_ff <= `COUNT_RESET;
      alarm_status_code_ff <= 6'h00;
      line_ff <= 6'h00;
      cbit_ff <= `CBIT_RESET;
      int_status_ff <= 3'h0;
      int_mask_ff <= 3'h0;
      rdata_ff <= 32'h0;
      irq_ff <= 1'b0;
    end else begin
      cont_ff <= nxt_cont;
      kind_sel_ff <= nxt_kind_sel;
      count_ff <= nxt_count;
      alarm_status_code_ff <= nxt_alarm_status_code;
      line_ff <= nxt_line;
      cbit_ff <= nxt_cbit;
      int_status_ff <= nxt_int_status;
      int_mask_ff <= nxt_int_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // Transmit sequencer and serializer
  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_kind = kind_ff;
    nxt_rep = rep_ff;
    nxt_bit_idx = bit_idx_ff;
    nxt_cur_code = cur_code_ff;
    nxt_tx_out = tx_out_ff;
    burst_done = 1'b0;
    word_end = feac_slot && (bit_idx_ff == `WORD_LAST_IDX);
    // FEAC bit or programmed C-bit per slot
    if (tx_cbit_req) begin
      if (feac_slot && (cont_ff || (tx_state_ff != ds3_feac_pkg::TX_IDLE))) begin
        nxt_tx_out = feac_bit;
      end else if (cbit_valid(tx_cbit_row, tx_cbit_pos)) begin
        nxt_tx_out = cbit_ff[cbit_index(tx_cbit_row, tx_cbit_pos)];
      end else begin
        nxt_tx_out = 1'b1;
      end
    end
    case (tx_state_ff)
      ds3_feac_pkg::TX_IDLE: begin
        if ((inject_key || sw_trigger) && (kind_sel_ff != `KIND_NONE)
            && (count_ff != 4'h0)) begin
          nxt_tx_state = ds3_feac_pkg::TX_CODE;
          nxt_kind = kind_sel_ff;
          nxt_rep = count_ff;
          nxt_bit_idx = 4'h0;
          case (kind_sel_ff)
            `KIND_ACTIVATE: nxt_cur_code = `LOOP_UP_CODE;
            `KIND_DEACTIVATE: nxt_cur_code = `LOOP_DOWN_CODE;
            default: nxt_cur_code = alarm_status_code_ff;
          endcase
        end else if (cont_ff) begin
          if (feac_slot) begin
            nxt_bit_idx = 4'(bit_idx_ff + 4'h1);
          end
          if (word_end || (bit_idx_ff == 4'h0)) begin
            nxt_cur_code = alarm_status_code_ff;
          end
        end else begin
          nxt_bit_idx = 4'h0;
          nxt_cur_code = alarm_status_code_ff;
        end
      end
      ds3_feac_pkg::TX_CODE, ds3_feac_pkg::TX_LINE: begin
        if (feac_slot) begin
          nxt_bit_idx = 4'(bit_idx_ff + 4'h1);
        end
        if (word_end) begin
          nxt_rep = 4'(rep_ff - 4'h1);
          if (rep_ff == 4'h1) begin
            if ((tx_state_ff == ds3_feac_pkg::TX_CODE) && (kind_ff != `KIND_ALARM)) begin
              nxt_tx_state = ds3_feac_pkg::TX_LINE;
              nxt_rep = count_ff;
              nxt_cur_code = line_ff;
            end else begin
              nxt_tx_state = ds3_feac_pkg::TX_IDLE;
              nxt_bit_idx = 4'h0;
              nxt_cur_code = alarm_status_code_ff;
              burst_done = 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_tx_state = ds3_feac_pkg::TX_IDLE;
        nxt_bit_idx = 4'h0;
      end
    endcase
  end

  // Transmit flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_ff <= ds3_feac_pkg::TX_IDLE;
      kind_ff <= `KIND_NONE;
      rep_ff <= 4'h0;
      bit_idx_ff <= 4'h0;
      cur_code_ff <= 6'h00;
      tx_out_ff <= 1'b1;
    end else begin
      tx_state_ff <= nxt_tx_state;
      kind_ff <= nxt_kind;
      rep_ff <= nxt_rep;
      bit_idx_ff <= nxt_bit_idx;
      cur_code_ff <= nxt_cur_code;
      tx_out_ff <= nxt_tx_out;
    end
  end

  // Receive codeword detection and sequence tracking
  always_comb begin
    logic [15:0] shifted;
    shifted = {rx_sr_ff[14:0], rx_feac_bit};
    nxt_rx_sr = rx_sr_ff;
    nxt_last_rx_code = last_rx_code_ff;
    nxt_last_rx_sequence_type = last_rx_sequence_type_ff;
    nxt_last_rx_line = last_rx_line_ff;
    nxt_pend = pend_ff;
    nxt_pend_kind = pend_kind_ff;
    rx_code_evt = 1'b0;
    rx_seq_evt = 1'b0;
    if (rx_feac_valid) begin
      nxt_rx_sr = shifted;
      if (!shifted[15] && !shifted[8] && (shifted[7:0] == `WORD_ONES)) begin
        nxt_rx_sr = 16'h0;
        rx_code_evt = 1'b1;
        nxt_last_rx_code = shifted[14:9];
        if ((shifted[14:9] == `LOOP_UP_CODE) || (shifted[14:9] == `LOOP_DOWN_CODE)) begin
          nxt_pend = 1'b1;
          nxt_pend_kind = (shifted[14:9] == `LOOP_UP_CODE);
        end else if (pend_ff) begin
          nxt_pend = 1'b0;
          rx_seq_evt = 1'b1;
          nxt_last_rx_sequence_type = pend_kind_ff;
          nxt_last_rx_line = shifted[14:9];
        end
      end
    end
  end

  // Receive flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sr_ff <= 16'h0;
      last_rx_code_ff <= 6'h00;
      last_rx_sequence_type_ff <= 1'b0;
      last_rx_line_ff <= 6'h00;
      pend_ff <= 1'b0;
      pend_kind_ff <= 1'b0;
    end else begin
      rx_sr_ff <= nxt_rx_sr;
      last_rx_code_ff <= nxt_last_rx_code;
      last_rx_sequence_type_ff <= nxt_last_rx_sequence_type;
      last_rx_line_ff <= nxt_last_rx_line;
      pend_ff <= nxt_pend;
      pend_kind_ff <= nxt_pend_kind;
    end
  end

  // One-second tick and elapsed counters
  always_comb begin
    sec_pulse = (tick_ff == 32'(TICKS_PER_SECOND - 1));
    nxt_tick = sec_pulse ? 32'h0 : 32'(tick_ff + 32'h1);
    nxt_seconds_since_rx_code = seconds_since_rx_code_ff;
    nxt_seconds_since_rx_sequence = seconds_since_rx_sequence_ff;
    if (rx_code_evt) begin
      nxt_seconds_since_rx_code = 32'h0;
    end else if (sec_pulse && (seconds_since_rx_code_ff != 32'hFFFFFFFF)) begin
      nxt_seconds_since_rx_code = 32'(seconds_since_rx_code_ff + 32'h1);
    end
    if (rx_seq_evt) begin
      nxt_seconds_since_rx_sequence = 32'h0;
    end else if (sec_pulse && (seconds_since_rx_sequence_ff != 32'hFFFFFFFF)) begin
      nxt_seconds_since_rx_sequence = 32'(seconds_since_rx_sequence_ff + 32'h1);
    end
  end

  // Seconds flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_ff <= 32'h0;
      seconds_since_rx_code_ff <= 32'h0;
      seconds_since_rx_sequence_ff <= 32'h0;
    end else begin
      tick_ff <= nxt_tick;
      seconds_since_rx_code_ff <= nxt_seconds_since_rx_code;
      seconds_since_rx_sequence_ff <= nxt_seconds_since_rx_sequence;
    end
  end

endmodule

// file: ds3_feac_channel_control_assertions.sv
`timescale 1ns/10ps
`include "ds3_feac_defines.svh"

module ds3_feac_channel_control_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Trigger, slots, receive, interrupt
  input wire logic inject_key,
  input wire logic tx_cbit_req,
  input wire logic [2:0] tx_cbit_row,
  input wire logic [1:0] tx_cbit_pos,
  input wire logic tx_cbit_out,
  input wire logic rx_feac_valid,
  input wire logic rx_feac_bit,
  input wire logic irq
);
  logic [2:0] mask_ff, nxt_mask;
  logic [5:0] alarm_ff, nxt_alarm;
  logic [20:0] table_ff, nxt_table;
  logic slot_bit;
  logic feac_slot;
  logic set_ok;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Shadow of software-written state
  always_comb begin
    nxt_mask = (reg_wr && reg_addr == `REG_INT_MASK) ? reg_wdata[2:0] : mask_ff;
    nxt_alarm = (reg_wr && reg_addr == `REG_ALARM) ? reg_wdata[5:0] : alarm_ff;
    nxt_table = (reg_wr && reg_addr == `REG_CBIT_TABLE) ? reg_wdata[20:0] : table_ff;
    set_ok = reg_wdata[2:0] != 3'h0 && reg_wdata[5:4] != 2'h0;
    if (reg_wr && reg_addr == `REG_CBIT_SET && set_ok) begin
      nxt_table[int'(reg_wdata[2:0]) * 3 + int'(reg_wdata[5:4]) - 4] = reg_wdata[8];
    end
    slot_bit = table_ff[int'(tx_cbit_row) * 3 + int'(tx_cbit_pos) - 4];
    feac_slot = tx_cbit_row == `FEAC_ROW && tx_cbit_pos == `FEAC_POS;
  end

  // Shadow registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_ff <= 3'h0;
      alarm_ff <= 6'h00;
      table_ff <= `CBIT_RESET;
    end else begin
      mask_ff <= nxt_mask;
      alarm_ff <= nxt_alarm;
      table_ff <= nxt_table;
    end
  end

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data seen without a read");
  unmapped_read_a: assert property (reg_rd && reg_addr > `REG_STATUS |=> reg_rdata == 32'h0)
    else $error("unmapped index returned data");
  mask_read_a: assert property (reg_rd && reg_addr == `REG_INT_MASK
    |=> reg_rdata == {29'h0, $past(mask_ff)})
    else $error("mask readback wrong");
  alarm_read_a: assert property (reg_rd && reg_addr == `REG_ALARM
    |=> reg_rdata == {26'h0, $past(alarm_ff)})
    else $error("alarm code readback wrong");
  table_read_a: assert property (reg_rd && reg_addr == `REG_CBIT_TABLE
    |=> reg_rdata == {11'h0, $past(table_ff)})
    else $error("C-bit table readback wrong");
  cbit_hold_a: assert property (!$past(tx_cbit_req) |-> $stable(tx_cbit_out))
    else $error("slot answer changed without request");
  cbit_refuse_a: assert property (tx_cbit_req && (tx_cbit_row == 3'h0 ||
    tx_cbit_pos == 2'h0) |=> tx_cbit_out)
    else $error("invalid slot not answered with one");
  cbit_table_a: assert property (tx_cbit_req && tx_cbit_row != 3'h0 &&
    tx_cbit_pos != 2'h0 && !feac_slot |=> tx_cbit_out == $past(slot_bit))
    else $error("slot answer differs from table");
  mask_quiet_a: assert property (mask_ff == 3'h0 && $past(mask_ff) == 3'h0 |-> !irq)
    else $error("interrupt raised while all masked");

  trigger_c: cover property (inject_key);
  feac_slot_c: cover property (tx_cbit_req && feac_slot && !tx_cbit_out);
  rx_bit_c: cover property (rx_feac_valid);
  irq_c: cover property ($rose(irq));
endmodule

// file: ds3_feac_far_end.sv
`timescale 1ns/10ps
`include "ds3_feac_defines.svh"

module ds3_feac_far_end (
  // Clock
  input wire logic clk,
  // Transmit C-bit slots
  output logic tx_cbit_req,
  output logic [2:0] tx_cbit_row,
  output logic [1:0] tx_cbit_pos,
  input wire logic tx_cbit_out,
  // Received FEAC bits
  output logic rx_feac_valid,
  output logic rx_feac_bit
);
  // Idle levels
  initial begin
    tx_cbit_req = 1'b0;
    tx_cbit_row = 3'h0;
    tx_cbit_pos = 2'h0;
    rx_feac_valid = 1'b0;
    rx_feac_bit = 1'b0;
  end

  // one slot request, answer taken a cycle later
  task automatic get_cbit(input logic [2:0] row, input logic [1:0] pos, output logic b);
    @(posedge clk);
    tx_cbit_req <= 1'b1;
    tx_cbit_row <= row;
    tx_cbit_pos <= pos;
    @(posedge clk);
    tx_cbit_req <= 1'b0;
    tx_cbit_row <= ~row;
    tx_cbit_pos <= ~pos;
    @(posedge clk);
    b = tx_cbit_out;
  endtask

  // sixteen FEAC slots, first bit on top
  task automatic get_word(output logic [15:0] w);
    logic b;
    for (int i = 0; i < 16; i++) begin
      get_cbit(`FEAC_ROW, `FEAC_POS, b);
      w = {w[14:0], b};
    end
  endtask

  // codeword sent MSB first, gap slows it
  task automatic send_word(input logic [5:0] code, input int gap);
    logic [15:0] w;
    w = {1'b0, code, 1'b0, `WORD_ONES};
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      rx_feac_valid <= 1'b1;
      rx_feac_bit <= w[i];
      @(posedge clk);
      rx_feac_valid <= 1'b0;
      rx_feac_bit <= ~w[i];
      repeat (gap) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
endmodule

// file: test_ds3_feac_channel_control.sv
`timescale 1ns/10ps
`include "ds3_feac_defines.svh"

module test_ds3_feac_channel_control;
  logic clk, reset_n, reg_wr, reg_rd, inject_key, tx_cbit_req, tx_cbit_out;
  logic rx_feac_valid, rx_feac_bit, irq, b;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0] tx_cbit_row;
  logic [1:0] tx_cbit_pos;
  logic [15:0] w;
  int err_count;
  int checks;

  // Design with a short second
  ds3_feac_channel_control #(.TICKS_PER_SECOND(20)) u_ds3_feac_channel_control (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inject_key(inject_key),
    .tx_cbit_req(tx_cbit_req), .tx_cbit_row(tx_cbit_row), .tx_cbit_pos(tx_cbit_pos),
    .tx_cbit_out(tx_cbit_out), .rx_feac_valid(rx_feac_valid), .rx_feac_bit(rx_feac_bit),
    .irq(irq));

  // Line equipment model
  ds3_feac_far_end u_ds3_feac_far_end (
    .clk(clk), .tx_cbit_req(tx_cbit_req), .tx_cbit_row(tx_cbit_row),
    .tx_cbit_pos(tx_cbit_pos), .tx_cbit_out(tx_cbit_out),
    .rx_feac_valid(rx_feac_valid), .rx_feac_bit(rx_feac_bit));

  // Clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi);
    checks++;
    if ((d >= lo && d <= hi) !== 1'b1) begin
      $display("ERROR %s expected %0d..%0d seen %h", name, lo, hi, d);
      err_count++;
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic read_check(input logic [3:0] a, input logic [31:0] exp, input string name);
    reg_read(a);
    check(name, exp, d);
  endtask

  task automatic irq_check(input logic exp);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic pulse_key();
    @(posedge clk);
    inject_key <= 1'b1;
    @(posedge clk);
    inject_key <= 1'b0;
  endtask

  task automatic expect_words(input int n, input logic [5:0] code, input string name);
    for (int i = 0; i < n; i++) begin
      u_ds3_feac_far_end.get_word(w);
      check(name, {16'h0, 1'b0, code, 1'b0, `WORD_ONES}, {16'h0, w});
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, inject_key, reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values and C-bit settings
    read_check(`REG_CTRL, 32'h30, "ctrl");
    read_check(`REG_CBIT_TABLE, 32'h1FFFFF, "table");
    u_ds3_feac_far_end.get_cbit(`FEAC_ROW, `FEAC_POS, b);
    check("feac idle", 32'h1, {31'h0, b});
    reg_write(`REG_CBIT_SET, 32'h031);
    reg_write(`REG_CBIT_SET, 32'h017);
    reg_write(`REG_CBIT_SET, 32'h010);
    read_check(`REG_CBIT_TABLE, 32'h1BFFFB, "table set");
    u_ds3_feac_far_end.get_cbit(3'h7, 2'h1, b);
    check("row7", 32'h0, {31'h0, b});
    u_ds3_feac_far_end.get_cbit(`FEAC_ROW, `FEAC_POS, b);
    check("feac static", 32'h0, {31'h0, b});
    u_ds3_feac_far_end.get_cbit(3'h0, 2'h1, b);
    check("row0", 32'h1, {31'h0, b});
    reg_write(`REG_CBIT_TABLE, 32'hFFFFFFFB);
    read_check(`REG_CBIT_TABLE, 32'h1FFFFB, "table write");
    u_ds3_feac_far_end.get_cbit(3'h7, 2'h1, b);
    check("row7 table", 32'h1, {31'h0, b});
    reg_write(4'hD, 32'hFFFFFFFF);
    read_check(4'hD, 32'h0, "unmapped");
    reg_write(`REG_ALARM, 32'h19);
    reg_write(`REG_LINE, 32'h2F);
    reg_write(`REG_CTRL, 32'h33);
    pulse_key();
    read_check(`REG_STATUS, 32'h1, "busy");
    expect_words(3, `LOOP_UP_CODE, "loop up");
    expect_words(3, 6'h2F, "line");
    expect_words(2, 6'h19, "continuous");
    // Burst done interrupt, masked then unmasked
    read_check(`REG_INT_STATUS, 32'h4, "status");
    irq_check(1'b0);
    reg_write(`REG_INT_MASK, 32'h4);
    irq_check(1'b1);
    reg_write(`REG_INT_STATUS, 32'h4);
    irq_check(1'b0);
    reg_write(`REG_CTRL, 32'h34);
    reg_write(`REG_ACTION, 32'h0);
    expect_words(3, `LOOP_DOWN_CODE, "loop down");
    expect_words(3, 6'h2F, "line");
    u_ds3_feac_far_end.get_cbit(`FEAC_ROW, `FEAC_POS, b);
    check("restore", 32'h0, {31'h0, b});
    // alarm burst_count_field 15, retrigger while busy ignored
    reg_write(`REG_CBIT_SET, 32'h131);
    reg_write(`REG_ALARM, 32'h2A);
    read_check(`REG_ALARM, 32'h2A, "alarm");
    reg_write(`REG_CTRL, 32'hF6);
    pulse_key();
    expect_words(7, 6'h2A, "alarm burst");
    pulse_key();
    expect_words(8, 6'h2A, "alarm burst");
    u_ds3_feac_far_end.get_word(w);
    check("after burst", 32'hFFFF, {16'h0, w});
    reg_write(`REG_CTRL, 32'h30);
    pulse_key();
    read_check(`REG_STATUS, 32'h0, "none busy");
    u_ds3_feac_far_end.get_word(w);
    check("none", 32'hFFFF, {16'h0, w});
    reg_write(`REG_INT_STATUS, 32'h7);
    reg_write(`REG_INT_MASK, 32'h1);
    read_check(`REG_INT_MASK, 32'h1, "mask");
    u_ds3_feac_far_end.send_word(`LOOP_UP_CODE, 2);
    irq_check(1'b1);
    u_ds3_feac_far_end.send_word(6'h05, 2);
    read_check(`REG_RX_SEQ, 32'h0501, "sequence");
    repeat (60) @(posedge clk);
    u_ds3_feac_far_end.send_word(6'h12, 0);
    read_check(`REG_RX_CODE, 32'h12, "rx code");
    reg_read(`REG_SEC_CODE);
    check_range("code seconds", 0, 1);
    reg_read(`REG_SEC_SEQ);
    check_range("sequence seconds", 4, 6);
    u_ds3_feac_far_end.send_word(`LOOP_DOWN_CODE, 0);
    u_ds3_feac_far_end.send_word(6'h2A, 0);
    read_check(`REG_RX_SEQ, 32'h2A00, "sequence");
    read_check(`REG_RX_CODE, 32'h2A, "rx code");
    reg_read(`REG_SEC_SEQ);
    check_range("sequence seconds", 0, 1);
    read_check(`REG_INT_STATUS, 32'h3, "rx status");
    reg_write(`REG_INT_STATUS, 32'h3);
    irq_check(1'b0);
    finish_test();
  end
endmodule

bind ds3_feac_channel_control ds3_feac_channel_control_assertions
  u_ds3_feac_channel_control_assertions (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inject_key(inject_key),
  .tx_cbit_req(tx_cbit_req), .tx_cbit_row(tx_cbit_row), .tx_cbit_pos(tx_cbit_pos),
  .tx_cbit_out(tx_cbit_out), .rx_feac_valid(rx_feac_valid), .rx_feac_bit(rx_feac_bit),
  .irq(irq));
